// ==== verilog/ovr_power_defines.svh ====
`ifndef OVR_POWER_DEFINES_SVH
`define OVR_POWER_DEFINES_SVH

// register addresses
`define ADDR_OVERRANGE_THRESHOLD_LEVEL 12'h0211
`define ADDR_OVERRANGE_CONFIG         12'h0213
`define ADDR_INITIALIZATION_STATUS    12'h0270
`define ADDR_POWER_PROFILE_SECOND     12'h029A
`define ADDR_POWER_PROFILE_THIRD      12'h029B

// reset values
`define RST_OVERRANGE_THRESHOLD       8'hF2
`define RST_OVERRANGE_CONFIG          8'h07
`define RST_POWER_PROFILE_SECOND      8'h0F
`define RST_POWER_PROFILE_THIRD       8'h04

// field positions in the over-range config register
`define OVERRANGE_CONFIG_ENABLE_BIT            3
`define OVERRANGE_CONFIG_EXP_MSB               2
`define OVERRANGE_CONFIG_EXP_LSB               0

// accepted power codes for the second profile register
`define POWER2_LOW_POWER              8'h06
`define POWER2_HIGH_PERF              8'h0F

// pulse stretch base: 4 * 2^N sampling cycles
`define OVR_HOLD_BASE_LOG2            2
`define OVR_INIT_CYCLES               16

`endif

// ==== verilog/ovr_power_pkg.sv ====
package ovr_power_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [11:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      INIT_RUN  = 2'b00,
      INIT_DONE = 2'b01
   } init_state_t;
endpackage : ovr_power_pkg

// ==== verilog/ovr_power_regs.sv ====
`timescale 1ns/10ps
`include "ovr_power_defines.svh"
module ovr_power_regs #(
   parameter int SAMPLE_W   = 12,
   parameter int INIT_CYCLES = `OVR_INIT_CYCLES
) (
   input  wire logic                   CLOCK,
   input  wire logic                   RST_N,
   input  wire ovr_power_pkg::reg_req_t REQ,
   output      logic [7:0]             RDATA,
   input  wire logic [4*SAMPLE_W-1:0]  SAMPLES,
   output      logic [3:0]             OVERRANGE_FLAGS,
   output      logic [7:0]             POWER_PROFILE_CODE_SECOND,
   output      logic [7:0]             POWER_PROFILE_THIRD
);
   localparam int CNT_W = 10;

   logic [7:0]       thr_reg, thr_next;
   logic [7:0]       cfg_reg, cfg_next;
   logic [7:0]       pw2_reg, pw2_next;
   logic [7:0]       pw3_reg, pw3_next;
   logic [7:0]       rdata_reg, rdata_next;
   logic [4:0]       init_cnt_reg, init_cnt_next;
   ovr_power_pkg::init_state_t init_reg, init_next;
   logic [3:0]       flag_reg, flag_next;
   logic [CNT_W-1:0] hold_reg [4];
   logic [CNT_W-1:0] hold_next [4];
   logic [3:0]       hit;
   logic [CNT_W-1:0] hold_len;
   logic             overrange_output_enable;

   assign overrange_output_enable   = cfg_reg[`OVERRANGE_CONFIG_ENABLE_BIT];
   // 4 * 2^N, N up to 7 gives 512 cycles
   assign hold_len = CNT_W'(1) << (`OVR_HOLD_BASE_LOG2
                     + cfg_reg[`OVERRANGE_CONFIG_EXP_MSB:`OVERRANGE_CONFIG_EXP_LSB]);

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         logic signed [SAMPLE_W-1:0] s;
         logic        [SAMPLE_W-1:0] mag;
         logic        [7:0]          top;
         assign s   = SAMPLES[g*SAMPLE_W +: SAMPLE_W];
         assign mag = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
         // top 8 magnitude bits against code/256 of full scale
         assign top = mag[SAMPLE_W-1] ? 8'hFF : mag[SAMPLE_W-2 -: 8];
         assign hit[g] =
            (top >= thr_reg);
      end
   endgenerate

   always_comb begin
      flag_next = flag_reg;
      for (int i = 0; i < 4; i++) begin
         hold_next[i] = hold_reg[i];
         if (hit[i]) begin
            flag_next[i] = 1'b1;
            hold_next[i] = hold_len - CNT_W'(1);
         end else if (hold_reg[i] != '0) begin
            hold_next[i] = hold_reg[i] - CNT_W'(1);
         end else begin
            flag_next[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         flag_reg <= 4'h0;
         for (int i = 0; i < 4; i++) hold_reg[i] <= '0;
      end else begin
         flag_reg <= flag_next;
         for (int i = 0; i < 4; i++) hold_reg[i] <= hold_next[i];
      end
   end

   assign OVERRANGE_FLAGS = overrange_output_enable ? flag_reg : 4'h0;

   always_comb begin
      init_next     = init_reg;
      init_cnt_next = init_cnt_reg;
      case (init_reg)
         ovr_power_pkg::INIT_RUN: begin
            init_cnt_next = init_cnt_reg + 5'h01;
            if (init_cnt_reg == 5'(INIT_CYCLES - 1))
               init_next = ovr_power_pkg::INIT_DONE;
         end
         ovr_power_pkg::INIT_DONE: init_next = ovr_power_pkg::INIT_DONE;
         default: init_next = ovr_power_pkg::INIT_RUN;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         init_reg     <= ovr_power_pkg::INIT_RUN;
         init_cnt_reg <= 5'h00;
      end else begin
         init_reg     <= init_next;
         init_cnt_reg <= init_cnt_next;
      end
   end

   always_comb begin
      thr_next   = thr_reg;
      cfg_next   = cfg_reg;
      pw2_next   = pw2_reg;
      pw3_next   = pw3_reg;
      rdata_next = rdata_reg;
      if (REQ.wr) begin
         case (REQ.addr)
            `ADDR_OVERRANGE_THRESHOLD_LEVEL: thr_next = REQ.wdata;
            `ADDR_OVERRANGE_CONFIG: cfg_next = {4'h0, REQ.wdata[3:0]};
            `ADDR_POWER_PROFILE_SECOND: begin
               // reserved codes are dropped so the mode never goes undefined
               if (REQ.wdata == `POWER2_LOW_POWER ||
                   REQ.wdata == `POWER2_HIGH_PERF)
                  pw2_next = REQ.wdata;
            end
            `ADDR_POWER_PROFILE_THIRD: pw3_next = REQ.wdata;
            default: ;
         endcase
      end
      if (REQ.rd) begin
         case (REQ.addr)
            `ADDR_OVERRANGE_THRESHOLD_LEVEL: rdata_next = thr_reg;
            `ADDR_OVERRANGE_CONFIG: rdata_next = cfg_reg;
            `ADDR_INITIALIZATION_STATUS:
               rdata_next = {7'h00, init_reg == ovr_power_pkg::INIT_DONE};
            `ADDR_POWER_PROFILE_SECOND: rdata_next = pw2_reg;
            `ADDR_POWER_PROFILE_THIRD: rdata_next = pw3_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         thr_reg   <= `RST_OVERRANGE_THRESHOLD;
         cfg_reg   <= `RST_OVERRANGE_CONFIG;
         pw2_reg   <= `RST_POWER_PROFILE_SECOND;
         pw3_reg   <= `RST_POWER_PROFILE_THIRD;
         rdata_reg <= 8'h00;
      end else begin
         thr_reg   <= thr_next;
         cfg_reg   <= cfg_next;
         pw2_reg   <= pw2_next;
         pw3_reg   <= pw3_next;
         rdata_reg <= rdata_next;
      end
   end

   assign RDATA                     = rdata_reg;
   assign POWER_PROFILE_CODE_SECOND = pw2_reg;
   assign POWER_PROFILE_THIRD       = pw3_reg;

   // length of each channel-0 flag run, and the length its last hit asked
   // for; captured at the hit so a mid-pulse exponent change stays legal
   logic [CNT_W:0]   run_reg, run_next;
   logic [CNT_W-1:0] want_reg, want_next;

   always_comb begin
      run_next  = run_reg;
      want_next = want_reg;
      if (hit[0])
         want_next = hold_len;
      if (!flag_reg[0])
         run_next = '0;
      else if (run_reg != '1)
         run_next = run_reg + (CNT_W+1)'(1);
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         run_reg  <= '0;
         want_reg <= '0;
      end else begin
         run_reg  <= run_next;
         want_reg <= want_next;
      end
   end

   default clocking chk_clk @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);

   sequence hit_seq(i);
      hit[i] && overrange_output_enable;
   endsequence

   flag_hold_a: assert property (
      hit_seq(0) ##1 !hit[0] |-> flag_reg[0] [*4])
      else $error("over-range pulse shorter than minimum");
   flag_width_a: assert property (
      $fell(flag_reg[0]) |-> run_reg >= {1'b0, want_reg})
      else $error("over-range pulse shorter than its hold length");
   flag_gate_a: assert property (
      !overrange_output_enable |-> OVERRANGE_FLAGS == 4'h0)
      else $error("over-range flags not gated");
   flag_rise_a: assert property (
      hit_seq(1) |=> OVERRANGE_FLAGS[1] || !overrange_output_enable)
      else $error("over-range flag missed");
   chan_alone_a: assert property (
      $rose(flag_reg[2]) |-> $past(hit[2]))
      else $error("flag raised without own channel hit");
   init_flag_a: assert property (
      init_reg == ovr_power_pkg::INIT_DONE
      |=> init_reg == ovr_power_pkg::INIT_DONE)
      else $error("init complete dropped");
   power_code_a: assert property (
      pw2_reg == `POWER2_LOW_POWER || pw2_reg == `POWER2_HIGH_PERF)
      else $error("reserved power code stored");
   thr_write_a: assert property (
      REQ.wr && REQ.addr == `ADDR_OVERRANGE_THRESHOLD_LEVEL
      |=> thr_reg == $past(REQ.wdata))
      else $error("threshold write lost");
   init_time_a: assert property (
      $rose(init_reg == ovr_power_pkg::INIT_DONE)
      |-> $past(init_cnt_reg) == 5'(INIT_CYCLES - 1))
      else $error("init finished early");
endmodule : ovr_power_regs

// ==== bench/host_port.sv ====
`timescale 1ns/10ps
module host_port (
   input  wire logic                    CLOCK,
   input  wire logic [7:0]              RDATA,
   output      ovr_power_pkg::reg_req_t REQ
);
   initial REQ = '0;
   // one access per call; request held across exactly one rising edge
   task automatic access(input logic w, input logic [11:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      @(negedge CLOCK);
      REQ = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge CLOCK);
      REQ = '0;
      q = RDATA;
   endtask : access
endmodule : host_port

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   logic                    clock;
   logic                    rst_n;
   ovr_power_pkg::reg_req_t req;
   logic [7:0]              rdata;
   logic [47:0]             samples;
   logic [3:0]              flags;
   logic [7:0]              pw2;
   logic [7:0]              pw3;
   logic [7:0]              q;
   int                      errors;
   int                      check_count;
   int                      n;
   ovr_power_regs dut (.CLOCK(clock), .RST_N(rst_n), .REQ(req),
      .RDATA(rdata), .SAMPLES(samples), .OVERRANGE_FLAGS(flags),
      .POWER_PROFILE_CODE_SECOND(pw2), .POWER_PROFILE_THIRD(pw3));
   host_port host (.CLOCK(clock), .RDATA(rdata), .REQ(req));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      host.access(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e, string s);
      host.access(1'b0, a, 8'h00, q);
      check(s, q, e);
   endtask : rd
   // one-cycle hit on one channel, then measure how long its flag stands
   task automatic pulse(input int ch, input logic [11:0] s, input int len);
      @(negedge clock);
      samples[ch*12 +: 12] = s;
      @(negedge clock);
      samples = '0;
      check("flag_hit", {4'h0, flags}, 8'h01 << ch);
      n = 0;
      repeat (300) begin
         if (flags[ch] === 1'b1) n++;
         @(negedge clock);
      end
      check("flag_len", n[7:0], len[7:0]);
   endtask : pulse
   initial begin
      errors = 0;
      check_count = 0;
      rst_n = 1'b0;
      samples = '0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      rd(12'h0270, 8'h00, "init_early");
      n = 0;
      do begin
         host.access(1'b0, 12'h0270, 8'h00, q);
         n++;
      end while (q !== 8'h01 && n < 100);
      check("init_done", q, 8'h01);
      if (n >= 100) summarize();
      rd(12'h0211, 8'hF2, "thr_rst");
      rd(12'h0213, 8'h07, "cfg_rst");
      rd(12'h029A, 8'h0F, "pw2_rst");
      rd(12'h029B, 8'h04, "pw3_rst");
      samples = {4{12'h7FF}};
      repeat (3) @(negedge clock);
      check("gated", {4'h0, flags}, 8'h00);
      samples = '0;
      // the gated hits still stretch for 4*2^7 cycles; let that run out
      repeat (530) @(negedge clock);
      check("gated_hold", {4'h0, flags}, 8'h00);
      wr(12'h0213, 8'hF8);
      rd(12'h0213, 8'h08, "cfg_rsvd");
      samples[11:0] = 12'h78F;
      repeat (3) @(negedge clock);
      check("below_thr", {4'h0, flags}, 8'h00);
      samples = '0;
      for (int k = 0; k < 3; k++) begin
         wr(12'h0213, 8'h08 | k[7:0]);
         pulse(k + 1, k == 1 ? 12'h870 : 12'h790, 4 << k);
      end
      wr(12'h0211, 8'h80);
      rd(12'h0211, 8'h80, "thr_wr");
      pulse(0, 12'h400, 16);
      // no sample is checked after a power profile mode change
      wr(12'h029A, 8'h06);
      wr(12'h029B, 8'h00);
      rd(12'h029A, 8'h06, "pw2_low");
      check("pw2_port", pw2, 8'h06);
      check("pw3_port", pw3, 8'h00);
      wr(12'h029A, 8'h07);
      rd(12'h029A, 8'h06, "pw2_rsvd");
      wr(12'h029A, 8'h0F);
      wr(12'h029B, 8'h04);
      rd(12'h029A, 8'h0F, "pw2_high");
      rd(12'h029B, 8'h04, "pw3_high");
      rd(12'h0212, 8'h00, "unmapped");
      summarize();
   end
endmodule : tb_top
